/* bench/pcpu_prot_model.sv */
// Purpose: protection logic guarding a protected write region
// Assumes: write flag aligned with the supervisor pin
// Notes: grants only supervisor-qualified writes
`timescale 1ns/1ps
module pcpu_prot_model (
  // qualifiers
  input wire logic sup_access_in,
  input wire logic prot_wr_in,
  // verdict
  output logic grant_out
);
  assign grant_out = prot_wr_in & sup_access_in;
endmodule : pcpu_prot_model

/* bench/pcpu_unit_bench.sv */
// Purpose: self-checking bench for pcpu_unit
// Assumes: 25 MHz clock, inputs change on the falling edge
// Notes: driver queues notes; monitor compares one cycle later
`timescale 1ns/1ps
module pcpu_unit_bench
  import pcpu_pkg::*;
;
  localparam logic [38:0] ALL = 39'h7f_ffff_ffff;
  localparam logic [38:0] CW = 39'h7f_ffff_ffe6;
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic int_req_in, int_return_in, fault_entry_in, fault_return_in, call_super_in;
  logic call_return_in, instr_retire_in, reinit_in, trace_event_in, bus_req_in;
  logic bus_instr_super_in, int_service_out, int_post_out, trace_active_out;
  logic sup_access_out, wr_d, sd, grant, s;
  logic [4:0] int_prio_in;
  logic [31:0] saved_pc_in, mod_mask_in, mod_value_in, process_controls_out, mod_old_out, m, v;
  logic [77:0] q[$];
  logic [77:0] nt;
  logic [4:0] pr[5] = '{5'h0a, 5'h09, 5'h0c, 5'h1f, 5'h1f};
  pcpu_op_t op_in;
  pcpu_fault_t fault_out;
  pcpu_stack_t stack_out;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  int d = 0;

  pcpu_unit pcpu_unit_i (.*);
  pcpu_prot_model pcpu_prot_model_i (.sup_access_in(sup_access_out), .prot_wr_in(wr_d),
    .grant_out(grant));

  // *****
  // tasks
  // *****
  task automatic idle;
    {int_req_in, int_return_in, fault_entry_in, fault_return_in, call_super_in} = '0;
    {call_return_in, instr_retire_in, reinit_in, trace_event_in} = '0;
    op_in = PCPU_OP_NONE;
  endtask : idle

  task automatic go(input logic [38:0] e, input logic [38:0] c);
    q.push_back({e, c});
    @(negedge mclk_in);
    idle();
    bus_req_in = 1'($urandom);
    bus_instr_super_in = 1'($urandom);
    @(negedge mclk_in);
  endtask : go

  task automatic chk(input logic [38:0] got, input logic [38:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  initial forever #20 mclk_in = ~mclk_in;

  always @(posedge mclk_in) {wr_d, sd} <= {bus_req_in, bus_req_in & bus_instr_super_in};

  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      failures++;
      conclude();
    end
  end

  always @(posedge mclk_in) begin
    #1;
    if (arst_n_in) begin
      chk(39'(grant), 39'(sd));
      if (q.size() > 0) begin
        nt = q.pop_front();
        chk({process_controls_out, fault_out, stack_out, int_service_out, int_post_out,
          trace_active_out} & nt[38:0], nt[77:39] & nt[38:0]);
      end
    end
  end

  initial begin
    {saved_pc_in, mod_mask_in, mod_value_in, int_prio_in, bus_req_in, bus_instr_super_in} = '0;
    idle();
    v = $urandom(32'he79e_235b);
    repeat (12) @(negedge mclk_in);
    arst_n_in = 1'b1;
    m = 32'h001f_2002;
    go({m, PCPU_FAULT_NONE, PCPU_STACK_SUPERVISOR, 3'h0}, ALL);
    repeat (4) begin
      op_in = PCPU_OP_MODIFY;
      mod_mask_in = $urandom & 32'hffff_dffd;
      mod_value_in = $urandom;
      v = mod_mask_in & PCPU_DEFINED_MASK;
      m = (m & ~v) | (mod_value_in & v);
      go({m, 7'h00}, CW);
    end
    op_in = PCPU_OP_MODIFY;
    mod_mask_in = 32'h001f_2401;
    mod_value_in = 32'h000a_0001;
    m = (m & ~mod_mask_in) | mod_value_in;
    go({m, 7'h00}, CW);
    for (int i = 0; i < 4; i++) begin
      instr_retire_in = 1'b1;
      go({m, 7'h01}, CW | 39'(i == 3));
    end
    trace_event_in = 1'b1;
    m[10] = 1'b1;
    go({m, 7'h00}, CW);
    foreach (pr[i]) begin
      int_req_in = 1'b1;
      int_prio_in = pr[i];
      s = pr[i] > m[20:16] || pr[i] == 5'h1f;
      if (s) begin
        m[20:16] = pr[i];
        m[13] = 1'b1;
        d++;
      end
      go({m, 4'h0, s, !s, 1'b0}, CW);
    end
    repeat (3) begin
      int_return_in = 1'b1;
      saved_pc_in = ($urandom & ~PCPU_DEFINED_MASK) | 32'h0005_0003;
      d--;
      m = (m & ~PCPU_DEFINED_MASK) | (saved_pc_in & PCPU_DEFINED_MASK);
      m[13] = d > 0;
      go({m, 7'h00}, CW);
    end
    op_in = PCPU_OP_MODIFY;
    mod_mask_in = 32'h0000_0002;
    mod_value_in = 32'h0000_0000;
    m[1] = 1'b0;
    go({m, 7'h00}, CW);
    for (int i = 1; i < 6; i++) begin
      op_in = pcpu_op_t'(i);
      reinit_in = op_in == PCPU_OP_SYSCTL;
      mod_mask_in = 32'hffff_ffff;
      s = op_in == PCPU_OP_SYSCTL || op_in == PCPU_OP_DMA_SETUP;
      go({m, s ? PCPU_FAULT_CONSTRAINT_PRIV : PCPU_FAULT_TYPE_MISMATCH, 5'h00}, CW);
    end
    fault_return_in = 1'b1;
    saved_pc_in = 32'h0003_0003;
    go({m, 7'h00}, CW);
    call_super_in = 1'b1;
    m[1] = 1'b1;
    go({m, 2'h0, PCPU_STACK_SUPERVISOR, 3'h0}, CW | 39'h18);
    go({m, 7'h00}, CW);
    call_return_in = 1'b1;
    m[1] = 1'b0;
    go({m, 7'h00}, CW);
    fault_entry_in = 1'b1;
    m[1] = 1'b1;
    go({m, 7'h00}, CW);
    fault_return_in = 1'b1;
    saved_pc_in = ($urandom & ~PCPU_DEFINED_MASK) | 32'h0007_0003;
    m = saved_pc_in & PCPU_DEFINED_MASK;
    go({m, 7'h00}, CW);
    op_in = PCPU_OP_SYSCTL;
    reinit_in = 1'b1;
    m = (m & 32'h001f_0000) | 32'h0000_2002;
    go({m, 7'h00}, CW);
    conclude();
  end
endmodule : pcpu_unit_bench

/* bench/pcpu_unit_monitor.sv */
// Purpose: port assertions for pcpu_unit
// Assumes: outputs registered one cycle after their cause
// Notes: bound into every pcpu_unit
`timescale 1ns/1ps
module pcpu_unit_monitor
  import pcpu_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // events
  input wire logic int_req_in,
  input wire logic [4:0] int_prio_in,
  input wire logic trace_event_in,
  input wire pcpu_op_t op_in,
  input wire logic [31:0] mod_mask_in,
  input wire logic reinit_in,
  input wire logic bus_req_in,
  input wire logic bus_instr_super_in,
  // outputs
  input wire logic [31:0] process_controls_out,
  input wire logic [31:0] mod_old_out,
  input wire logic int_service_out,
  input wire logic int_post_out,
  input wire pcpu_fault_t fault_out,
  input wire pcpu_stack_t stack_out,
  input wire logic sup_access_out
);
  // ******
  // checks
  // ******
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  wire [4:0] cur = process_controls_out[20:16];
  wire sup = process_controls_out[1];
  svc_take_a: assert property (
    int_req_in && !reinit_in && (int_prio_in > cur || &int_prio_in)
    |=> int_service_out && !int_post_out && cur == $past(int_prio_in)) else $error("service");
  post_keep_a: assert property (
    int_req_in && int_prio_in <= cur && !(&int_prio_in)
    |=> int_post_out && !int_service_out && $stable(cur)) else $error("post");
  int_state_a: assert property (
    int_service_out |-> process_controls_out[13] && sup && stack_out == PCPU_STACK_INTERRUPT)
    else $error("service state");
  modify_user_a: assert property (
    !sup && op_in == PCPU_OP_MODIFY |=> fault_out == PCPU_FAULT_TYPE_MISMATCH) else $error("modify");
  priv_fault_a: assert property (
    !sup && (op_in == PCPU_OP_SYSCTL || op_in == PCPU_OP_DMA_SETUP)
    |=> fault_out == PCPU_FAULT_CONSTRAINT_PRIV) else $error("privilege");
  sup_pin_a: assert property (
    bus_req_in |=> sup_access_out == $past(bus_instr_super_in)) else $error("sup pin");
  mask_keep_a: assert property (
    sup && op_in == PCPU_OP_MODIFY && !int_req_in && !trace_event_in
    |=> ((process_controls_out ^ $past(process_controls_out))
    & ~($past(mod_mask_in) & PCPU_DEFINED_MASK)) == 32'h0000_0000) else $error("mask");
  mod_old_a: assert property (
    sup && op_in == PCPU_OP_MODIFY |=> mod_old_out == $past(process_controls_out))
    else $error("modify old word");
  reinit_keep_a: assert property (
    sup && op_in == PCPU_OP_SYSCTL && reinit_in |=> process_controls_out
    == (($past(process_controls_out) & 32'h001f_0000) | 32'h0000_2002)) else $error("reinit");
endmodule : pcpu_unit_monitor

bind pcpu_unit pcpu_unit_monitor pcpu_unit_monitor_i (.*);

/* rtl/pcpu_arbiter.sv */
// Purpose: decide service or post for a requested interrupt
// Assumes: priorities are 5-bit, 31 always serviced
// Notes: combinational
`timescale 1ns/1ps
module pcpu_arbiter
  import pcpu_pkg::*;
(
  // priorities
  input wire logic [4:0] cur_prio_in,
  input wire logic [4:0] req_prio_in,
  input wire logic req_in,
  // decision
  output logic service_out,
  output logic post_out
);
  always_comb begin
    service_out = req_in && ((req_prio_in > cur_prio_in) || (req_prio_in == PCPU_PRIO_MAX));
    post_out = req_in && !service_out;
  end
endmodule : pcpu_arbiter

/* rtl/pcpu_pkg.sv */
// Purpose: constants and types of the process controls privilege unit
// Assumes: 32-bit process controls word
// Notes: field positions, reset values and operation codes
package pcpu_pkg;
  localparam int unsigned PCPU_W = 32;
  localparam int unsigned PCPU_TRACE_EN_BIT = 0;
  localparam int unsigned PCPU_MODE_BIT = 1;
  localparam int unsigned PCPU_TFP_BIT = 10;
  localparam int unsigned PCPU_STATE_BIT = 13;
  localparam int unsigned PCPU_PRIO_LO = 16;
  localparam int unsigned PCPU_PRIO_HI = 20;
  localparam int unsigned PCPU_PRIO_W = 5;
  localparam logic [4:0] PCPU_PRIO_MAX = 5'h1f;
  // bits the unit defines; the rest are reserved and preserved
  localparam logic [31:0] PCPU_DEFINED_MASK = 32'h001f_2403;
  localparam logic [31:0] PCPU_RESERVED_RESET = 32'h0000_0000;
  localparam logic [1:0] PCPU_TRACE_DELAY = 2'h3;
  localparam int unsigned PCPU_NEST_W = 6;

  // privileged operation classes
  typedef enum logic [2:0] {
    PCPU_OP_NONE,
    PCPU_OP_MODIFY,
    PCPU_OP_SYSCTL,
    PCPU_OP_DMA_SETUP,
    PCPU_OP_SFR_OPERAND,
    PCPU_OP_RAM_WRITE
  } pcpu_op_t;

  typedef enum logic [1:0] {
    PCPU_FAULT_NONE,
    PCPU_FAULT_TYPE_MISMATCH,
    PCPU_FAULT_CONSTRAINT_PRIV
  } pcpu_fault_t;

  typedef enum logic [1:0] {
    PCPU_STACK_USER,
    PCPU_STACK_SUPERVISOR,
    PCPU_STACK_INTERRUPT
  } pcpu_stack_t;

  // masked update: keep unselected bits
  function automatic logic [31:0] pcpu_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [31:0] mask_v);
    pcpu_merge = (old_v & ~mask_v) | (new_v & mask_v);
  endfunction : pcpu_merge
endpackage : pcpu_pkg

/* rtl/pcpu_priv_check.sv */
// Purpose: fault supervisor-only operations issued in user mode
// Assumes: operation class given per instruction
// Notes: combinational
`timescale 1ns/1ps
module pcpu_priv_check
  import pcpu_pkg::*;
(
  // request
  input wire logic supervisor_in,
  input wire pcpu_op_t op_in,
  // result
  output pcpu_fault_t fault_out,
  output logic allow_out
);
  always_comb begin
    fault_out = PCPU_FAULT_NONE;
    if (!supervisor_in) begin
      case (op_in)
        PCPU_OP_MODIFY: fault_out = PCPU_FAULT_TYPE_MISMATCH;
        PCPU_OP_SYSCTL: fault_out = PCPU_FAULT_CONSTRAINT_PRIV;
        PCPU_OP_DMA_SETUP: fault_out = PCPU_FAULT_CONSTRAINT_PRIV;
        PCPU_OP_SFR_OPERAND: fault_out = PCPU_FAULT_TYPE_MISMATCH;
        PCPU_OP_RAM_WRITE: fault_out = PCPU_FAULT_TYPE_MISMATCH;
        default: fault_out = PCPU_FAULT_NONE;
      endcase
    end
    allow_out = (op_in != PCPU_OP_NONE) && (fault_out == PCPU_FAULT_NONE);
  end
endmodule : pcpu_priv_check

/* rtl/pcpu_unit.sv */
// Purpose: process controls word, interrupt service decision, privilege
// Assumes: one core clock; events are one-cycle pulses from the core
// Notes: supervisor pin qualifies bus accesses of supervisor instructions
//
// Notes on behaviour
// - bit 1 is execution mode, 0 user, 1 supervisor.
// - supervisor call from user sets mode; its matching return clears it.
// - bit 13 is 1 while servicing an interrupt, else 0.
// - nested interrupts keep interrupted state until the outermost handler returns.
// - bits 16 to 20 hold current priority, 0 lowest, 31 highest.
// - service interrupt above current priority or at 31, else post it.
// - servicing an interrupt loads priority with its priority.
// - bit 0 enables trace faults; bit 10 flags a detected trace event.
// - modify operation only in supervisor mode, else type-mismatch fault.
// - modify operation reads word and changes only mask-selected bits.
// - handler return restores saved word only if in supervisor mode.
// - changes act at once; trace enable via modify may lag three instructions.
// - hardware reset: priority 31, supervisor, trace off, interrupted.
// - reinitialize applies reset conditions but keeps priority.
// - supervisor call into supervisor mode selects the supervisor stack.
// - supervisor pin asserted for bus accesses of supervisor instructions.
// - user mode faults sysctl, DMA setup, register operand, protected RAM write.
// - supervisor call stays supervisor until return to the calling procedure.
// - interrupt switches to supervisor mode but uses the interrupt stack.
`timescale 1ns/1ps
module pcpu_unit
  import pcpu_pkg::*;
#(
  parameter int unsigned NEST_DEPTH_W = PCPU_NEST_W
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // interrupt request
  input wire logic int_req_in,
  input wire logic [4:0] int_prio_in,
  input wire logic int_return_in,
  input wire logic fault_entry_in,
  input wire logic fault_return_in,
  input wire logic [31:0] saved_pc_in,
  // supervisor call and return
  input wire logic call_super_in,
  input wire logic call_return_in,
  // operation issue
  input wire logic instr_retire_in,
  input wire pcpu_op_t op_in,
  input wire logic [31:0] mod_mask_in,
  input wire logic [31:0] mod_value_in,
  input wire logic reinit_in,
  input wire logic trace_event_in,
  // bus access
  input wire logic bus_req_in,
  input wire logic bus_instr_super_in,
  // status out
  output logic [31:0] process_controls_out,
  output logic [31:0] mod_old_out,
  output logic int_service_out,
  output logic int_post_out,
  output pcpu_fault_t fault_out,
  output pcpu_stack_t stack_out,
  output logic trace_active_out,
  output logic sup_access_out
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [31:0] pcw;
    logic [31:0] mod_old;
    logic [NEST_DEPTH_W-1:0] nest;
    logic [NEST_DEPTH_W-1:0] call_depth;
    logic call_owner;
    logic trace_active;
    logic [1:0] trace_wait;
    logic trace_target;
    pcpu_stack_t stack;
    pcpu_fault_t fault;
    logic service;
    logic post;
    logic sup_access;
  } pcpu_state_t;

  pcpu_state_t st_reg;
  pcpu_state_t st_next;

  logic arb_service;
  logic arb_post;
  pcpu_fault_t chk_fault;
  logic chk_allow;

  // ****************************************
  // helpers
  // ****************************************
  pcpu_arbiter u_arbiter (
    .cur_prio_in(st_reg.pcw[PCPU_PRIO_HI:PCPU_PRIO_LO]),
    .req_prio_in(int_prio_in),
    .req_in(int_req_in),
    .service_out(arb_service),
    .post_out(arb_post)
  );

  pcpu_priv_check u_priv (
    .supervisor_in(st_reg.pcw[PCPU_MODE_BIT]),
    .op_in(op_in),
    .fault_out(chk_fault),
    .allow_out(chk_allow)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [31:0] pc_v;
    logic [31:0] sel_mask;
    pc_v = st_reg.pcw;
    sel_mask = 32'h0000_0000;
    st_next = st_reg;
    st_next.fault = chk_fault;
    st_next.service = arb_service;
    st_next.post = arb_post;
    st_next.sup_access = bus_req_in && bus_instr_super_in;

    // supervisor call from user mode
    if (call_super_in) begin
      if (!pc_v[PCPU_MODE_BIT] && (st_reg.call_depth == '0)) begin
        pc_v[PCPU_MODE_BIT] = 1'b1;
        st_next.call_owner = 1'b1;
        st_next.stack = PCPU_STACK_SUPERVISOR;
      end
      if (st_reg.call_owner || (!pc_v[PCPU_MODE_BIT])) begin
        st_next.call_depth = st_reg.call_depth + 1'b1;
      end else if (st_next.call_owner) begin
        st_next.call_depth = st_reg.call_depth + 1'b1;
      end
    end else if (call_return_in && st_reg.call_owner) begin
      st_next.call_depth = st_reg.call_depth - 1'b1;
      if (st_reg.call_depth == NEST_DEPTH_W'(1)) begin
        pc_v[PCPU_MODE_BIT] = 1'b0;
        st_next.call_owner = 1'b0;
        st_next.stack = PCPU_STACK_USER;
      end
    end

    // modify operation in supervisor mode
    if (op_in == PCPU_OP_MODIFY && chk_allow) begin
      st_next.mod_old = st_reg.pcw;
      sel_mask = mod_mask_in & PCPU_DEFINED_MASK;
      pc_v = pcpu_merge(pc_v, mod_value_in, sel_mask);
      if (sel_mask[PCPU_TRACE_EN_BIT]) begin
        st_next.trace_target = mod_value_in[PCPU_TRACE_EN_BIT];
        st_next.trace_wait = PCPU_TRACE_DELAY;
      end
    end

    // return from an interrupt or fault handler
    if (int_return_in || fault_return_in) begin
      if (st_reg.pcw[PCPU_MODE_BIT]) begin
        pc_v = pcpu_merge(pc_v, saved_pc_in, PCPU_DEFINED_MASK);
      end
      if (int_return_in && st_reg.nest != '0) begin
        st_next.nest = st_reg.nest - 1'b1;
        if (st_reg.nest == NEST_DEPTH_W'(1)) begin
          pc_v[PCPU_STATE_BIT] = 1'b0;
        end else begin
          pc_v[PCPU_STATE_BIT] = 1'b1;
        end
      end
      st_next.stack = pc_v[PCPU_MODE_BIT] ? PCPU_STACK_SUPERVISOR : PCPU_STACK_USER;
    end

    // trace event sets the pending flag; set beats a same-cycle modify or restore
    if (trace_event_in && st_reg.trace_active) begin
      pc_v[PCPU_TFP_BIT] = 1'b1;
    end

    // fault entry runs in supervisor mode
    if (fault_entry_in) begin
      pc_v[PCPU_MODE_BIT] = 1'b1;
    end

    // interrupt service
    if (arb_service) begin
      pc_v[PCPU_PRIO_HI:PCPU_PRIO_LO] = int_prio_in;
      pc_v[PCPU_STATE_BIT] = 1'b1;
      pc_v[PCPU_MODE_BIT] = 1'b1;
      st_next.stack = PCPU_STACK_INTERRUPT;
      if (st_reg.nest != '1) begin
        st_next.nest = st_next.nest + 1'b1;
      end
    end

    // trace enable lag after modify
    if (st_reg.trace_wait != 2'h0) begin
      if (instr_retire_in) begin
        st_next.trace_wait = st_reg.trace_wait - 2'h1;
        if (st_reg.trace_wait == 2'h1) begin
          st_next.trace_active = st_reg.trace_target;
        end
      end
    end else begin
      st_next.trace_active = pc_v[PCPU_TRACE_EN_BIT];
    end

    // reinitialize keeps priority
    if (reinit_in && chk_allow) begin
      pc_v[PCPU_MODE_BIT] = 1'b1;
      pc_v[PCPU_TRACE_EN_BIT] = 1'b0;
      pc_v[PCPU_STATE_BIT] = 1'b1;
      pc_v[PCPU_TFP_BIT] = 1'b0;
      st_next.trace_active = 1'b0;
      st_next.trace_wait = 2'h0;
      st_next.nest = '0;
      st_next.call_depth = '0;
      st_next.call_owner = 1'b0;
      st_next.stack = PCPU_STACK_SUPERVISOR;
    end

    st_next.pcw = pc_v;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_reg.pcw <= PCPU_RESERVED_RESET | 32'h001f_2002;
      st_reg.mod_old <= 32'h0000_0000;
      st_reg.nest <= '0;
      st_reg.call_depth <= '0;
      st_reg.call_owner <= 1'b0;
      st_reg.trace_active <= 1'b0;
      st_reg.trace_wait <= 2'h0;
      st_reg.trace_target <= 1'b0;
      st_reg.stack <= PCPU_STACK_SUPERVISOR;
      st_reg.fault <= PCPU_FAULT_NONE;
      st_reg.service <= 1'b0;
      st_reg.post <= 1'b0;
      st_reg.sup_access <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign process_controls_out = st_reg.pcw;
  assign mod_old_out = st_reg.mod_old;
  assign int_service_out = st_reg.service;
  assign int_post_out = st_reg.post;
  assign fault_out = st_reg.fault;
  assign stack_out = st_reg.stack;
  assign trace_active_out = st_reg.trace_active;
  assign sup_access_out = st_reg.sup_access;

endmodule : pcpu_unit
